// *** lcd_dma_model.sv ***
// display dma channel model feeding the gray lookup block
module lcd_dma_model
  import lcd_gray_pkg::*;
#(
  parameter logic [15:0] LOOK0 = 16'h0000,
  parameter logic [15:0] LOOK1 = 16'h0000,
  parameter logic [63:0] PATTERN = 64'h0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // stream setup
  input wire logic slow,
  input wire logic [4:0] tableWords,
  input wire logic [15:0] streamLen,
  // channel
  input wire logic dmaRequest,
  input wire logic endOfProcess,
  output dmaIn_t dmaIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // pointer reach is a 64K region
  logic [15:0] ptr;
  logic [2:0] gap;

  // table words first at base, bitmap only when none
  function automatic logic [15:0] wordAt(input logic [15:0] p,
                                         input logic [4:0] n);
    logic [15:0] k;
    k = p - {11'h0, n};
    if (p < {11'h0, n}) return p[0] ? LOOK1 : LOOK0;
    return PATTERN[63 - 16 * int'(k[1:0]) -: 16];
  endfunction

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dmaIn <= '0;
      ptr <= '0;
      gap <= '0;
    end else begin
      gap <= gap + 3'h1;
      if (dmaIn.dmaAcknowledge) begin
        dmaIn.dmaAcknowledge <= 1'b0;
        dmaIn.data <= ~dmaIn.data;
        if (dmaRequest) ptr <= ptr + 16'h1;
      end else if (endOfProcess) begin
        ptr <= '0;
        dmaIn.data <= ~dmaIn.data;
      end else if (dmaRequest && ptr < streamLen &&
                   (!slow || gap == 3'h0)) begin
        dmaIn.dmaAcknowledge <= 1'b1;
        dmaIn.data <= wordAt(ptr, tableWords);
      end else begin
        // idle bus toggles between the stale word and its complement
        dmaIn.data <= ~dmaIn.data;
      end
    end
  end
endmodule

// *** lcd_gray_lookup_fetch_decode.sv ***
// gray lookup fetch from the display dma stream and two-bit dot decode
// Summary of operation
// - pixel codes 00 bright, 01 light gray, 10 dark gray, 11 off.
// - code 00 always gives dot 0, code 11 always dot 1.
// - gray codes take the dot from the lookup word, row parity picks bits.
// - nibbles: 7-4 even dark, 3-0 even light, 15-12 odd dark, 11-8 odd light.
// - pair at byte bits 7:6 uses nibble top bit, lower pairs lower bits.
// - a zero-size table means the stream carries bitmap data only.
// - end_of_process after the final row's last word; dma reloads base.
// - count lookup words, keep the one the address counter selects.
// - counter reaching table size raises the refill request.
// - refill interrupt maskable; words keep cycling frame after frame.
// - the frame's lookup word moves into a dedicated decode register.
// - each selected nibble bit drives one of four panel data outputs.
// - request may stay asserted while the dma autoinitialises.
// - on enable, load both current and next frame lookup words.
// - one lookup word consumed per frame; N words last N frames.
// - lookup word count is programmable from zero to sixteen.
// - three-bit size code selects 0,2,4,6,8,10,12 or 16 words.
// - status bit set when dram lookup entries need refilling.
// - disable bit set suppresses the refill interrupt; reset clears it.
// - depth bit selects two bits per pixel when 1, one when 0.
module lcd_gray_lookup_fetch_decode
  import lcd_gray_pkg::*;
#(
  parameter int LOOKUP_MAX = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register bus
  input wire axiReq_t axiReq,
  output axiRsp_t axiRsp,
  // display dma channel
  input wire dmaIn_t dmaIn,
  output logic dmaRequest,
  output logic endOfProcess,
  // row and dot timing from the panel timing generator
  input wire rowTiming_t timing,
  // panel side
  output logic [3:0] panelDotData,
  output logic lookupRefillIrq
);

  if (LOOKUP_MAX != 16) begin : g_bad_lookup_max
    $error("LOOKUP_MAX must be 16: size code 7 selects sixteen words");
  end

  state_t st_reg;
  state_t st_next;

  logic enable;
  logic depth2;
  logic [4:0] nWords;
  logic [8:0] rowsPerFrame;
  logic [5:0] wordsPerRow;
  logic [4:0] addrInc;
  logic wrapHit;
  logic [4:0] nextIdx;
  logic [7:0] curByte;
  logic [3:0] decoded;
  logic lastNib;
  logic lastWord;
  logic [31:0] readValue;
  logic [1:0] readResp;

  assign enable = st_reg.ctrl[CTRL_ENABLE_POS];
  assign depth2 = st_reg.ctrl[CTRL_DEPTH_POS];
  assign nWords = lookupWords(st_reg.ctrl[CTRL_SIZE_POS +: 3]);
  assign rowsPerFrame =
    (st_reg.ctrl[CTRL_SCREEN_POS +: 2] == SCREEN_480) ? ROWS_320 :
    (st_reg.ctrl[CTRL_SCREEN_POS +: 2] == SCREEN_200) ? ROWS_200 : ROWS_240;
  assign wordsPerRow = (st_reg.ctrl[CTRL_SCREEN_POS +: 2] == SCREEN_480) ?
    (depth2 ? WPR_480_2BPP : WPR_480_1BPP) :
    (depth2 ? WPR_320_2BPP : WPR_320_1BPP);
  assign addrInc = {1'b0, st_reg.addr} + 5'h01;
  assign wrapHit = (addrInc == nWords);
  assign nextIdx = wrapHit ? 5'h00 : addrInc;

  // high byte leaves first, so its pixels reach the panel first
  assign curByte = st_reg.nibSel[0] ? st_reg.buffer[7:0] :
    st_reg.buffer[15:8];
  assign lastNib = depth2 ? st_reg.nibSel[0] : (st_reg.nibSel == 2'h3);
  assign lastWord = (st_reg.wordInRow == wordsPerRow - 6'h01) &&
    (st_reg.row == rowsPerFrame - 9'h001);

  for (genvar p = 0; p < 4; p++) begin : g_pix
    logic [1:0] code;
    logic grayBit;
    assign code = curByte[2*p +: 2];
    // odd rows use the upper byte
    // pair p uses nibble bit p
    assign grayBit = (code == CODE_DARK) ?
      st_reg.curLookup[(st_reg.rowOdd ? 12 : 4) + p] :
      st_reg.curLookup[(st_reg.rowOdd ? 8 : 0) + p];
    assign decoded[p] = !depth2 ?
      st_reg.buffer[15 - 4*st_reg.nibSel - (3 - p)] :
      (code == CODE_BRIGHT) ? 1'b0 :
      (code == CODE_OFF) ? 1'b1 : grayBit;
  end

  always_comb begin
    readValue = 32'h0000_0000;
    readResp = RESP_OKAY;
    if (axiReq.araddr == CTRL_OFFSET) begin
      readValue[7:0] = st_reg.ctrl;
    end else if (axiReq.araddr == STATUS_OFFSET) begin
      readValue[STAT_REFILL_POS] = st_reg.refill;
      readValue[STAT_ADDR_POS +: 4] = st_reg.addr;
      readValue[STAT_ODD_POS] = st_reg.rowOdd;
      readValue[STAT_LOOKUP_POS +: 16] = st_reg.curLookup;
    end else begin
      readResp = RESP_DECERR;
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.endOfProcess = 1'b0;

    // register bus: address and data taken in either order
    if (axiReq.awvalid && st_reg.rsp.awready) begin
      st_next.awHeld = 1'b1;
      st_next.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && st_reg.rsp.wready) begin
      st_next.wHeld = 1'b1;
      st_next.wData = axiReq.wdata;
      st_next.wStrb = axiReq.wstrb;
    end
    if (st_reg.rsp.bvalid && axiReq.bready) begin
      st_next.rsp.bvalid = 1'b0;
    end
    if (st_reg.awHeld && st_reg.wHeld && !st_reg.rsp.bvalid) begin
      st_next.awHeld = 1'b0;
      st_next.wHeld = 1'b0;
      st_next.rsp.bvalid = 1'b1;
      st_next.rsp.bresp = RESP_OKAY;
      if (st_reg.awAddr == CTRL_OFFSET) begin
        if (st_reg.wStrb[0]) begin
          st_next.ctrl = st_reg.wData[7:0];
        end
      end else if (st_reg.awAddr == STATUS_OFFSET) begin
        // write one clears; a same-cycle set below still wins
        if (st_reg.wStrb[0] && st_reg.wData[STAT_REFILL_POS]) begin
          st_next.refill = 1'b0;
        end
      end else begin
        st_next.rsp.bresp = RESP_DECERR;
      end
    end
    if (st_reg.rsp.rvalid && axiReq.rready) begin
      st_next.rsp.rvalid = 1'b0;
    end
    if (axiReq.arvalid && st_reg.rsp.arready) begin
      st_next.rsp.rvalid = 1'b1;
      st_next.rsp.rdata = readValue;
      st_next.rsp.rresp = readResp;
    end

    if (timing.frameStart) begin
      st_next.rowOdd = 1'b0;
      if (st_reg.swapPending) begin
        st_next.curLookup = st_reg.nextLookup;
        st_next.swapPending = 1'b0;
      end
    end else if (timing.rowPulse) begin
      st_next.rowOdd = !st_reg.rowOdd;
    end

    // dot output; an empty buffer drives the lines low
    if (timing.dotAdvance) begin
      st_next.dots = (st_reg.bufValid && enable) ? decoded : 4'h0;
      if (st_reg.bufValid) begin
        st_next.nibSel = st_reg.nibSel + 2'h1;
        if (lastNib) begin
          st_next.bufValid = 1'b0;
        end
      end
    end

    if (!enable) begin
      st_next.phase = PH_IDLE;
      st_next.dots = 4'h0;
      st_next.bufValid = 1'b0;
    end else if (st_reg.phase == PH_IDLE) begin
      st_next.phase = (nWords == 5'h00) ? PH_BITMAP : PH_LOOKUP;
      st_next.primed = 1'b0;
      st_next.swapPending = 1'b0;
      st_next.addr = 4'h0;
      st_next.idx = 5'h00;
      st_next.row = 9'h000;
      st_next.wordInRow = 6'h00;
    end else if (dmaIn.dmaAcknowledge && st_reg.dmaRequest) begin
      if (st_reg.phase == PH_LOOKUP) begin
        if (!st_reg.primed && st_reg.idx == {1'b0, st_reg.addr}) begin
          st_next.curLookup = dmaIn.data;
        end
        if ((st_reg.primed && st_reg.idx == {1'b0, st_reg.addr}) ||
            (!st_reg.primed && st_reg.idx == nextIdx)) begin
          st_next.nextLookup = dmaIn.data;
          st_next.swapPending = st_reg.primed;
        end
        st_next.idx = st_reg.idx + 5'h01;
        if (st_reg.idx == nWords - 5'h01) begin
          st_next.phase = PH_BITMAP;
        end
      end else begin
        st_next.buffer = dmaIn.data;
        st_next.bufValid = 1'b1;
        st_next.nibSel = 2'h0;
        st_next.wordInRow = st_reg.wordInRow + 6'h01;
        if (st_reg.wordInRow == wordsPerRow - 6'h01) begin
          st_next.wordInRow = 6'h00;
          st_next.row = st_reg.row + 9'h001;
        end
        if (lastWord) begin
          st_next.endOfProcess = 1'b1;
          st_next.row = 9'h000;
          st_next.idx = 5'h00;
          st_next.phase = (nWords == 5'h00) ? PH_BITMAP : PH_LOOKUP;
          st_next.primed = 1'b1;
          st_next.swapPending |= !st_reg.primed && nWords != 5'h00;
          st_next.addr = wrapHit ? 4'h0 : addrInc[3:0];
          if (wrapHit && nWords != 5'h00) begin
            st_next.refill = 1'b1;
          end
        end
      end
    end

    // request may stay up through the reload
    st_next.dmaRequest = enable && (st_next.phase != PH_IDLE) &&
      (st_next.phase == PH_LOOKUP || !st_next.bufValid);
    st_next.irq = st_next.refill && !st_next.ctrl[CTRL_IRQ_DIS_POS];
    st_next.rsp.awready = !st_next.awHeld && !st_next.rsp.bvalid;
    st_next.rsp.wready = !st_next.wHeld && !st_next.rsp.bvalid;
    st_next.rsp.arready = !st_next.rsp.rvalid;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign axiRsp = st_reg.rsp;
  assign dmaRequest = st_reg.dmaRequest;
  assign endOfProcess = st_reg.endOfProcess;
  assign panelDotData = st_reg.dots;
  assign lookupRefillIrq = st_reg.irq;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence dotTaken;
    timing.dotAdvance && st_reg.bufValid && enable;
  endsequence

  sequence lastWordTaken;
    st_reg.phase == PH_BITMAP && dmaIn.dmaAcknowledge &&
      st_reg.dmaRequest && lastWord && enable;
  endsequence

  chk_fixed_codes: assert property (
    dotTaken and depth2 && curByte[7:6] == CODE_OFF && curByte[1:0] ==
      CODE_BRIGHT |=> panelDotData[3] && !panelDotData[0])
    else $error("fixed codes decoded wrongly");

  chk_gray_nibble: assert property (
    dotTaken and depth2 && curByte[7:6] == CODE_DARK && st_reg.rowOdd
      |=> panelDotData[3] == $past(st_reg.curLookup[15]))
    else $error("odd row dark gray used wrong lookup bit");

  chk_light_even: assert property (
    dotTaken and depth2 && curByte[1:0] == CODE_LIGHT && !st_reg.rowOdd
      |=> panelDotData[0] == $past(st_reg.curLookup[0]))
    else $error("even row light gray used wrong lookup bit");

  chk_eop_pulse: assert property (
    lastWordTaken |=> endOfProcess ##1 !endOfProcess)
    else $error("end of process not a single pulse after last word");

  chk_zero_table: assert property (
    lastWordTaken and nWords == 5'h00 |=> st_reg.phase == PH_BITMAP)
    else $error("zero size table entered lookup phase");

  chk_refill_wrap: assert property (
    lastWordTaken and wrapHit && nWords != 5'h00
      |=> st_reg.refill && st_reg.addr == 4'h0)
    else $error("table end did not set refill and wrap counter");

  chk_irq_mask: assert property (
    st_reg.refill && st_reg.ctrl[CTRL_IRQ_DIS_POS] |=> !lookupRefillIrq)
    else $error("masked refill still raised the interrupt");

  chk_parity_reset: assert property (
    timing.frameStart |=> !st_reg.rowOdd)
    else $error("row parity not even after frame start");

  chk_request_held: assert property (
    lastWordTaken and nWords != 5'h00 |=> dmaRequest [*2])
    else $error("request dropped during lookup reload");

  chk_lookup_store: assert property (
    st_reg.phase == PH_LOOKUP && st_reg.primed && enable &&
      dmaIn.dmaAcknowledge && st_reg.dmaRequest &&
      st_reg.idx == {1'b0, st_reg.addr}
      |=> st_reg.nextLookup == $past(dmaIn.data))
    else $error("selected lookup word not stored");

endmodule

// *** lcd_gray_lookup_fetch_decode_tb.sv ***
// self-checking bench for the gray lookup fetch and decode block
module lcd_gray_lookup_fetch_decode_tb
  import lcd_gray_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] L0 = 16'h3CA5;
  localparam logic [15:0] L1 = 16'h96A5;
  localparam logic [63:0] PATTERN = 64'h1BE4_5555_AAAA_E41B;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic slow = 1'b1;
  axiReq_t axiReq = '0;
  axiRsp_t axiRsp;
  dmaIn_t dmaIn;
  rowTiming_t timing = '0;
  logic dmaRequest;
  logic endOfProcess;
  logic [3:0] panelDotData;
  logic lookupRefillIrq;
  int fail_count = 0;
  int compares = 0;
  logic [15:0] w;

  always #5 core_clk = ~core_clk;

  lcd_gray_lookup_fetch_decode #(.LOOKUP_MAX(16)) uut (
    .core_clk(core_clk), .sys_rst(sys_rst), .axiReq(axiReq),
    .axiRsp(axiRsp), .dmaIn(dmaIn), .dmaRequest(dmaRequest),
    .endOfProcess(endOfProcess), .timing(timing),
    .panelDotData(panelDotData), .lookupRefillIrq(lookupRefillIrq));

  // two lookup words, then 200 rows of 40 words
  lcd_dma_model #(.LOOK0(L0), .LOOK1(L1), .PATTERN(PATTERN)) dma (
    .core_clk(core_clk), .sys_rst(sys_rst), .slow(slow),
    .tableWords(5'h02), .streamLen(16'd8002), .dmaRequest(dmaRequest),
    .endOfProcess(endOfProcess), .dmaIn(dmaIn));

  task automatic complete_run();
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic busWrite(input logic [31:0] a, input logic [31:0] d,
                          input logic [1:0] er);
    logic awT, wT, bT;
    logic [1:0] r;
    r = 2'bxx;
    @(posedge core_clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hF;
    axiReq.bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge core_clk);
      awT = axiRsp.awready && axiReq.awvalid;
      wT = axiRsp.wready && axiReq.wvalid;
      bT = axiRsp.bvalid;
      r = axiRsp.bresp;
      @(posedge core_clk);
      if (awT) axiReq.awvalid <= 1'b0;
      if (wT) axiReq.wvalid <= 1'b0;
      if (bT) break;
    end
    axiReq.bready <= 1'b0;
    check({30'h0, r}, {30'h0, er});
  endtask

  task automatic busRead(input logic [31:0] a, input logic [31:0] exp,
                         input logic [1:0] er);
    logic arT, rT;
    logic [31:0] d;
    logic [1:0] r;
    r = 2'bxx;
    @(posedge core_clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge core_clk);
      arT = axiRsp.arready && axiReq.arvalid;
      rT = axiRsp.rvalid;
      d = axiRsp.rdata;
      r = axiRsp.rresp;
      @(posedge core_clk);
      if (arT) axiReq.arvalid <= 1'b0;
      if (rT) break;
    end
    axiReq.rready <= 1'b0;
    check(d, exp);
    check({30'h0, r}, {30'h0, er});
  endtask

  // waits on the request (sel 0) or end of process (sel 1)
  task automatic waitSig(input int sel, input logic lvl, input int lim);
    logic s;
    for (int n = 0; n < lim; n++) begin
      @(negedge core_clk);
      s = (sel == 0) ? dmaRequest : endOfProcess;
      if (s === lvl) break;
    end
    check({31'h0, s}, {31'h0, lvl});
  endtask

  task automatic pulse(input rowTiming_t p);
    @(posedge core_clk);
    timing <= rowTiming_t'(timing | p);
    @(posedge core_clk);
    timing <= rowTiming_t'(timing & ~p);
  endtask

  function automatic logic [3:0] dots(input logic [7:0] b, input logic odd,
                                      input logic [15:0] lk);
    logic [3:0] dk, lt, r;
    dk = odd ? lk[15:12] : lk[7:4];
    lt = odd ? lk[11:8] : lk[3:0];
    for (int i = 0; i < 4; i++) begin
      case (b[2*i +: 2])
        2'h0: r[i] = 1'b0;
        2'h1: r[i] = lt[i];
        2'h2: r[i] = dk[i];
        default: r[i] = 1'b1;
      endcase
    end
    return r;
  endfunction

  task automatic dotCheck(input logic [7:0] b, input logic odd);
    pulse(rowTiming_t'(3'b001));
    @(negedge core_clk);
    check({28'h0, panelDotData}, {28'h0, dots(b, odd, L0)});
  endtask

  initial begin
    // run is about two frames of 8002 words at four cycles each
    #990000;
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    busRead(CTRL_OFFSET, 32'h0, RESP_OKAY);
    busRead(STATUS_OFFSET, 32'h0, RESP_OKAY);
    busRead(32'h8, 32'h0, RESP_DECERR);
    busWrite(32'hC, 32'h1, RESP_DECERR);
    // enable, 2 bpp, two table words, 200 rows
    busWrite(CTRL_OFFSET, 32'h4B, RESP_OKAY);
    busRead(CTRL_OFFSET, 32'h4B, RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      w = PATTERN[63 - 16 * k -: 16];
      waitSig(0, 1'b1, 60);
      waitSig(0, 1'b0, 60);
      if (k == 2) pulse(rowTiming_t'(3'b010));
      dotCheck(w[15:8], k >= 2);
      dotCheck(w[7:0], k >= 2);
    end
    busRead(STATUS_OFFSET, {L0, 16'h0020}, RESP_OKAY);
    @(posedge core_clk);
    timing <= rowTiming_t'(3'b001);
    slow <= 1'b0;
    waitSig(1, 1'b1, 50000);
    busRead(STATUS_OFFSET, {L0, 16'h0022}, RESP_OKAY);
    waitSig(0, 1'b0, 60);
    pulse(rowTiming_t'(3'b100));
    busRead(STATUS_OFFSET, {L1, 16'h0002}, RESP_OKAY);
    waitSig(1, 1'b1, 50000);
    busRead(STATUS_OFFSET, {L1, 16'h0001}, RESP_OKAY);
    check({31'h0, lookupRefillIrq}, 32'h1);
    busWrite(CTRL_OFFSET, 32'h4F, RESP_OKAY);
    @(negedge core_clk);
    check({31'h0, lookupRefillIrq}, 32'h0);
    busWrite(STATUS_OFFSET, 32'h1, RESP_OKAY);
    busRead(STATUS_OFFSET, {L1, 16'h0000}, RESP_OKAY);
    complete_run();
  end
endmodule

// *** lcd_gray_pkg.sv ***
// constants, types and state layout for the gray lookup fetch and decode block
package lcd_gray_pkg;

  localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
  localparam int CTRL_ENABLE_POS = 0;
  localparam int CTRL_DEPTH_POS = 1;
  localparam int CTRL_IRQ_DIS_POS = 2;
  localparam int CTRL_SIZE_POS = 3;
  localparam int CTRL_SCREEN_POS = 6;
  localparam int STAT_REFILL_POS = 0;
  localparam int STAT_ADDR_POS = 1;
  localparam int STAT_ODD_POS = 5;
  localparam int STAT_LOOKUP_POS = 16;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [1:0] SCREEN_200 = 2'h1;
  localparam logic [1:0] SCREEN_480 = 2'h2;
  localparam logic [8:0] ROWS_240 = 9'h0F0;
  localparam logic [8:0] ROWS_200 = 9'h0C8;
  localparam logic [8:0] ROWS_320 = 9'h140;
  localparam logic [5:0] WPR_320_2BPP = 6'h28;
  localparam logic [5:0] WPR_320_1BPP = 6'h14;
  localparam logic [5:0] WPR_480_2BPP = 6'h3C;
  localparam logic [5:0] WPR_480_1BPP = 6'h1E;
  localparam logic [1:0] CODE_BRIGHT = 2'h0;
  localparam logic [1:0] CODE_LIGHT = 2'h1;
  localparam logic [1:0] CODE_DARK = 2'h2;
  localparam logic [1:0] CODE_OFF = 2'h3;

  typedef enum logic [1:0] {PH_IDLE, PH_LOOKUP, PH_BITMAP} phase_t;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } axiReq_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axiRsp_t;

  typedef struct packed {
    logic dmaAcknowledge;
    logic [15:0] data;
  } dmaIn_t;

  typedef struct packed {
    logic frameStart;
    logic rowPulse;
    logic dotAdvance;
  } rowTiming_t;

  typedef struct packed {
    axiRsp_t rsp;
    logic awHeld;
    logic [31:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic [7:0] ctrl;
    logic refill;
    phase_t phase;
    logic primed;
    logic swapPending;
    logic [3:0] addr;
    logic [4:0] idx;
    logic [15:0] curLookup;
    logic [15:0] nextLookup;
    logic bufValid;
    logic [15:0] buffer;
    logic [1:0] nibSel;
    logic [5:0] wordInRow;
    logic [8:0] row;
    logic rowOdd;
    logic dmaRequest;
    logic endOfProcess;
    logic [3:0] dots;
    logic irq;
  } state_t;

  localparam state_t STATE_RESET = '0;

  // table size code to word count: 0,2,4,...,12 then 16
  function automatic logic [4:0] lookupWords(input logic [2:0] code);
    return (code == 3'h7) ? 5'h10 : {1'b0, code, 1'b0};
  endfunction

endpackage
